// *** shared/crs_consts.vh ***
`ifndef CRS_CONSTS_VH
`define CRS_CONSTS_VH
`define CRS_DEV_ADDR       5'h1E
`define CRS_REG_RESET      16'h000E
`define CRS_REG_STATUS     16'h000F
`define CRS_REG_ERRTALLY   16'h0010
`define CRS_RESET_VAL      16'h0000
`define CRS_STATUS_RST     16'h0000
`define CRS_BIT_DATAPATH   3
`define CRS_BIT_TXCLR      2
`define CRS_BIT_RXCLR      1
`define CRS_BIT_RSV0       0
`define CRS_RSV_LO_MSB     7
`define CRS_RSV_LO_LSB     4
`define CRS_OP_ADDR        2'b00
`define CRS_OP_WRITE       2'b01
`define CRS_OP_READ        2'b11
`define CRS_OP_RDINC       2'b10
`endif

// *** verilog/crs_mdc_sync.v ***
`timescale 1ns/1ns
// two-stage synchroniser plus rising edge detect on the second stage copy
module crs_mdc_sync (
  // clock and reset
  input  wire core_clk,
  input  wire sys_rst,
  // asynchronous input
  input  wire asyncIn,
  // synchronised level and rising edge
  output wire syncOut,
  output wire riseOut
);
  reg meta_ff;
  reg sync_ff;
  reg prev_ff;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      meta_ff <= asyncIn;
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end
  assign syncOut = sync_ff;
  assign riseOut = sync_ff & ~prev_ff;
endmodule

// *** verilog/crs_mdio_slave.v ***
`timescale 1ns/1ns
`include "crs_consts.vh"
// clause-45 style frame engine: shifts mdio on mdc rising edges and drives reads
module crs_mdio_slave (
  // clock and reset
  input  wire        core_clk,
  input  wire        sys_rst,
  // synchronised link
  input  wire        mdcRise,
  input  wire        mdioIn,
  output reg         mdioOut,
  output reg         mdioOe,
  // register access
  output reg         regWr,
  output reg  [15:0] regAddr,
  output reg  [15:0] regWdata,
  input  wire [15:0] regRdata,
  output reg         regRd
);
  localparam ST_IDLE = 2'd0;
  localparam ST_HEAD = 2'd1;
  localparam ST_DATA = 2'd2;
  reg [1:0]  state_ff;
  reg [5:0]  cnt_ff;
  reg [15:0] sh_ff;
  reg [1:0]  op_ff;
  reg        mine_ff;
  reg [15:0] rd_ff;
  reg [5:0]  preCnt_ff;
  always @(posedge core_clk) begin
    if (sys_rst) begin
      state_ff  <= ST_IDLE;
      cnt_ff    <= 6'h00;
      sh_ff     <= 16'h0000;
      op_ff     <= 2'b00;
      mine_ff   <= 1'b0;
      rd_ff     <= 16'h0000;
      preCnt_ff <= 6'h00;
      mdioOut   <= 1'b1;
      mdioOe    <= 1'b0;
      regWr     <= 1'b0;
      regRd     <= 1'b0;
      regAddr   <= 16'h0000;
      regWdata  <= 16'h0000;
    end else begin
      regWr <= 1'b0;
      regRd <= 1'b0;
      if (mdcRise) begin
        sh_ff <= {sh_ff[14:0], mdioIn};
        case (state_ff)
          ST_IDLE: begin
            mdioOe <= 1'b0;
            if (mdioIn)
              preCnt_ff <= (preCnt_ff == 6'h3F) ? preCnt_ff : preCnt_ff + 6'h01;
            else begin
              // start bit after preamble of at least 32 ones
              if (preCnt_ff >= 6'h20) begin
                state_ff <= ST_HEAD;
                cnt_ff   <= 6'h00;
              end
              preCnt_ff <= 6'h00;
            end
          end
          ST_HEAD: begin
            cnt_ff <= cnt_ff + 6'h01;
            // after st(1 left) op(2) prtad(5) devad(5) = 13 bits, ta follows
            if (cnt_ff == 6'h02)
              op_ff <= {sh_ff[0], mdioIn};
            if (cnt_ff == 6'h0C)
              mine_ff <= ({sh_ff[3:0], mdioIn} == `CRS_DEV_ADDR); // RQ9
            if (cnt_ff == 6'h0D && mine_ff && op_ff[1]) begin
              regRd <= 1'b1;
              rd_ff <= regRdata;
            end
            if (cnt_ff == 6'h0E) begin
              state_ff <= ST_DATA;
              cnt_ff   <= 6'h00;
              if (mine_ff && op_ff[1]) begin
                mdioOe  <= 1'b1;
                mdioOut <= rd_ff[15];
                rd_ff   <= {rd_ff[14:0], 1'b0};
              end
            end
          end
          ST_DATA: begin
            cnt_ff <= cnt_ff + 6'h01;
            if (mdioOe) begin
              mdioOut <= rd_ff[15];
              rd_ff   <= {rd_ff[14:0], 1'b0};
            end
            if (cnt_ff == 6'h0F) begin
              state_ff  <= ST_IDLE;
              mdioOe    <= 1'b0;
              preCnt_ff <= 6'h00;
              if (mine_ff) begin
                if (op_ff == `CRS_OP_ADDR)
                  regAddr <= {sh_ff[14:0], mdioIn};
                else if (op_ff == `CRS_OP_WRITE) begin
                  regWdata <= {sh_ff[14:0], mdioIn};
                  regWr    <= 1'b1;
                end else if (op_ff == `CRS_OP_RDINC)
                  regAddr <= regAddr + 16'h0001;
              end
            end
          end
          default: state_ff <= ST_IDLE;
        endcase
      end
    end
  end
endmodule

// *** verilog/crs_channel_regs.v ***
`timescale 1ns/1ns
`include "crs_consts.vh"
// How it works
// (RQ1) each reset strobe clears itself on the next management clock cycle
// (RQ2) bit 3 resets all channel datapath logic but not the registers
// (RQ3) station issues datapath reset after configuring the functional mode
// (RQ4) bit 2 clears the transmit FIFO, only in plain 10G mode
// (RQ5) bit 1 clears the receive FIFO, only in plain 10G mode
// (RQ6) in backplane KR mode FIFOs self-centre; software clear not needed
// (RQ7) reset register bits 15:8 always read zero
// (RQ8) reset register sits at 0x000E and resets to 0x0000
// (RQ9) registers answer at management device address 0x1E
// (RQ10) read-only status register sits at 0x000F, reads 0x0000 after reset
// (RQ11) bit 15 shows test-pattern lock, valid only in 10G and KX modes
// (RQ12) test-pattern bit errors accumulate in the error tally at 0x10
// (RQ13) bit 14 reads zero when system lane alignment is achieved
// (RQ14) bit 13 reads one on line loss of signal
// (RQ15) bit 12 reads one once auto-zero calibration finished
// (RQ16) bits 7..4 report tx under/over, rx under/over; underflows n/a in KX
// (RQ17) bits 1 and 0 report system and line PLL lock
// (RQ18) bit 8 reports invalid code word or disparity error when decoding
// (RQ19) bit 11 reports gain loop lock, bit 10 line sync
// (RQ20) writing zero to a strobe does nothing; strobe reads zero after clearing
module crs_channel_regs (
  // clock and reset
  input  wire        core_clk,
  input  wire        sys_rst,
  // management link pins
  input  wire        mdcPin,
  input  wire        mdioPinIn,
  output wire        mdioPinOut,
  output wire        mdioPinOe,
  // mode selection
  input  wire        backplaneKrMode,
  input  wire        gigabitKxMode,
  // status conditions from the channel
  input  wire        patternLockFlag,
  input  wire        systemLaneAlignFlag,
  input  wire        lineSignalLost,
  input  wire        autozeroFinished,
  input  wire        gainLoopLocked,
  input  wire        lineSyncFlag,
  input  wire        badCodewordFlag,
  input  wire        decoderEnabled,
  input  wire        txUnderflow,
  input  wire        txOverflow,
  input  wire        rxUnderflow,
  input  wire        rxOverflow,
  input  wire        rxLinkOk,
  input  wire        txLinkOk,
  input  wire        systemSidePllLocked,
  input  wire        lineSidePllLocked,
  input  wire        patternBitError,
  // channel reset outputs
  output reg         datapathReset,
  output reg         txBufferClear,
  output reg         rxBufferClear,
  // error tally value
  output reg  [15:0] lineErrorTally
);
  wire        mdcSync;
  wire        mdcRise;
  wire        mdioSync;
  wire        regWr;
  wire        regRd;
  wire [15:0] regAddr;
  wire [15:0] regWdata;
  reg  [15:0] regRdata;
  reg  [3:1]  strobe_ff;
  reg  [3:0]  rsvLo_ff;
  reg         rsv0_ff;
  reg  [15:0] status_ff;
  reg         tallyClear_ff;
  reg  [15:0] nxt_status;

  // sampling of the asynchronous management pins
  crs_mdc_sync uMdc (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  (mdcPin),
    .syncOut  (mdcSync),
    .riseOut  (mdcRise)
  );
  crs_mdc_sync uMdio (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .asyncIn  (mdioPinIn),
    .syncOut  (mdioSync),
    .riseOut  ()
  );

  crs_mdio_slave uSlave (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .mdcRise  (mdcRise),
    .mdioIn   (mdioSync),
    .mdioOut  (mdioPinOut),
    .mdioOe   (mdioPinOe),
    .regWr    (regWr),
    .regAddr  (regAddr),
    .regWdata (regWdata),
    .regRdata (regRdata),
    .regRd    (regRd)
  );

  // reset register; strobes live for one mdc cycle
  always @(posedge core_clk) begin
    if (sys_rst) begin
      strobe_ff <= 3'b000; // RQ8
      rsvLo_ff  <= 4'h0;
      rsv0_ff   <= 1'b0;
    end else begin
      if (mdcRise)
        strobe_ff <= 3'b000; // RQ1
      if (regWr && regAddr == `CRS_REG_RESET) begin
        // zeros leave strobes alone
        strobe_ff <= strobe_ff | regWdata[`CRS_BIT_DATAPATH:`CRS_BIT_RXCLR]; // RQ20
        rsvLo_ff  <= regWdata[`CRS_RSV_LO_MSB:`CRS_RSV_LO_LSB];
        rsv0_ff   <= regWdata[`CRS_BIT_RSV0];
      end
    end
  end

  // outputs into the channel; register file itself never reset by these
  always @(posedge core_clk) begin
    if (sys_rst) begin
      datapathReset <= 1'b0;
      txBufferClear <= 1'b0;
      rxBufferClear <= 1'b0;
    end else begin
      datapathReset <= strobe_ff[`CRS_BIT_DATAPATH]; // RQ2
      // fifo clears only act in plain 10G mode; KR fifos self-centre
      txBufferClear <= strobe_ff[`CRS_BIT_TXCLR] & ~backplaneKrMode & ~gigabitKxMode; // RQ4 RQ6
      rxBufferClear <= strobe_ff[`CRS_BIT_RXCLR] & ~backplaneKrMode & ~gigabitKxMode; // RQ5 RQ6
    end
  end

  // status capture
  always @* begin
    nxt_status                = 16'h0000;
    nxt_status[15] = patternLockFlag & ~backplaneKrMode; // RQ11
    nxt_status[14] = ~systemLaneAlignFlag; // RQ13
    nxt_status[13] = lineSignalLost; // RQ14
    nxt_status[12] = autozeroFinished; // RQ15
    nxt_status[11] = gainLoopLocked; // RQ19
    nxt_status[10] = lineSyncFlag; // RQ19
    nxt_status[8]  = badCodewordFlag & decoderEnabled; // RQ18
    nxt_status[7]  = txUnderflow & ~gigabitKxMode; // RQ16
    nxt_status[6]  = txOverflow; // RQ16
    nxt_status[5]  = rxUnderflow & ~gigabitKxMode; // RQ16
    nxt_status[4]  = rxOverflow; // RQ16
    nxt_status[3]  = rxLinkOk;
    nxt_status[2]  = txLinkOk;
    nxt_status[1]  = systemSidePllLocked; // RQ17
    nxt_status[0]  = lineSidePllLocked; // RQ17
  end

  always @(posedge core_clk) begin
    if (sys_rst)
      status_ff <= `CRS_STATUS_RST; // RQ10
    else
      status_ff <= nxt_status;
  end

  // error tally, cleared on read, saturating; an error in the clearing cycle counts
  always @(posedge core_clk) begin
    if (sys_rst) begin
      lineErrorTally <= 16'h0000;
      tallyClear_ff  <= 1'b0;
    end else begin
      tallyClear_ff <= regRd && regAddr == `CRS_REG_ERRTALLY;
      if (tallyClear_ff)
        lineErrorTally <= {15'h0000, patternBitError & status_ff[15]};
      else if (patternBitError && status_ff[15] && lineErrorTally != 16'hFFFF)
        lineErrorTally <= lineErrorTally + 16'h0001; // RQ12
    end
  end

  // read mux, only device 0x1E frames reach here
  always @* begin
    if (regAddr == `CRS_REG_RESET) // RQ8
      regRdata = {8'h00, rsvLo_ff, strobe_ff, rsv0_ff}; // RQ7 RQ20
    else if (regAddr == `CRS_REG_STATUS)
      regRdata = status_ff; // RQ10
    else if (regAddr == `CRS_REG_ERRTALLY)
      regRdata = lineErrorTally; // RQ12
    else
      regRdata = 16'h0000;
  end
endmodule

// *** verification/crs_channel_regs_sva.sv ***
`timescale 1ns/1ns
module crs_channel_regs_sva (
  // clock and reset
  input wire        core_clk,
  input wire        sys_rst,
  // modes and pattern check
  input wire        backplaneKrMode,
  input wire        gigabitKxMode,
  input wire        patternBitError,
  // observed outputs
  input wire        mdioPinOut,
  input wire        mdioPinOe,
  input wire        datapathReset,
  input wire        txBufferClear,
  input wire        rxBufferClear,
  input wire [15:0] lineErrorTally
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  reg [7:0] oeCnt_ff;
  always @(posedge core_clk) begin
    if (sys_rst || !mdioPinOe) oeCnt_ff <= 8'h00;
    else if (oeCnt_ff != 8'hFF) oeCnt_ff <= oeCnt_ff + 8'h01;
  end
  property p_dp_clear;
    $rose(datapathReset) |-> ##[1:16] !datapathReset;
  endproperty
  a_dp_clear: assert property (p_dp_clear) else $error("datapath strobe stuck");
  property p_buf_clear;
    $rose(txBufferClear || rxBufferClear) |-> ##[1:16] !(txBufferClear || rxBufferClear);
  endproperty
  a_buf_clear: assert property (p_buf_clear) else $error("buffer strobe stuck");
  property p_tx_gate;
    $rose(txBufferClear) |-> !backplaneKrMode && !gigabitKxMode;
  endproperty
  a_tx_gate: assert property (p_tx_gate) else $error("tx clear outside 10G");
  property p_rx_gate;
    $rose(rxBufferClear) |-> !backplaneKrMode && !gigabitKxMode;
  endproperty
  a_rx_gate: assert property (p_rx_gate) else $error("rx clear outside 10G");
  property p_kr_quiet;
    backplaneKrMode |-> !txBufferClear && !rxBufferClear;
  endproperty
  a_kr_quiet: assert property (p_kr_quiet) else $error("buffer clear in KR");
  property p_rst_idle;
    disable iff (1'b0) sys_rst |=> !datapathReset && !mdioPinOe && mdioPinOut;
  endproperty
  a_rst_idle: assert property (p_rst_idle) else $error("outputs busy in reset");
  property p_tally_step;
    !$stable(lineErrorTally) |->
      lineErrorTally == $past(lineErrorTally) + 16'h0001 || lineErrorTally == 16'h0000;
  endproperty
  a_tally_step: assert property (p_tally_step) else $error("tally jumped");
  property p_tally_cause;
    lineErrorTally == $past(lineErrorTally) + 16'h0001 |->
      $past(patternBitError) || $past(patternBitError, 2);
  endproperty
  a_tally_cause: assert property (p_tally_cause) else $error("tally without error");
  property p_oe_bound;
    oeCnt_ff <= 8'h8C;
  endproperty
  a_oe_bound: assert property (p_oe_bound) else $error("read drive too long");
  c_dp: cover property ($rose(datapathReset));
  c_read: cover property ($rose(mdioPinOe));
  c_tally: cover property (lineErrorTally == 16'h0005);
endmodule

// *** verification/crs_mdio_station.sv ***
`timescale 1ns/1ns
module crs_mdio_station (
  // link pins
  output reg  mdc,
  output reg  mdioEn,
  output reg  mdioDrv,
  input  wire mdioIn
);
  initial begin
    mdc = 1'b0;
    mdioEn = 1'b0;
    mdioDrv = 1'b1;
  end
  // bit shown in the low half, read data taken just before the rise
  task bitCycle(input reg en, input reg val, output reg smp);
    begin
      mdioEn = en;
      mdioDrv = val;
      #200;
      smp = mdioIn;
      mdc = 1'b1;
      #200;
      mdc = 1'b0;
    end
  endtask
  task frame(input reg [1:0] op, input reg [4:0] dev, input reg [15:0] data,
             output reg [15:0] rd);
    reg [63:0] bits;
    reg s;
    integer i;
    begin
      bits = {32'hFFFFFFFF, 2'b00, op, 5'h00, dev, 2'b10, data};
      for (i = 63; i >= 0; i = i - 1) begin
        bitCycle(!(op[1] && i < 18), bits[i], s);
        if (i < 16) rd[i] = s;
      end
      // idle cycle so strobes see their next mdc edge
      bitCycle(1'b0, 1'b1, s);
    end
  endtask
endmodule

// *** verification/channel_reset_and_status_regs_tb.sv ***
`timescale 1ns/1ns
module channel_reset_and_status_regs_tb;
  reg core_clk, sysRst, krMode, kxMode, patErr;
  reg [15:0] stv, rd;
  wire mdc, stEn, stDrv, dutOut, dutOe, dpRst, txClr, rxClr;
  wire [15:0] tally;
  wire mdioWire = dutOe ? dutOut : (stEn ? stDrv : 1'b1);
  integer error_cnt, checks_done, dpCnt, txCnt, rxCnt, i;
  crs_mdio_station st (.mdc(mdc), .mdioEn(stEn), .mdioDrv(stDrv), .mdioIn(mdioWire));
  crs_channel_regs uut (
    .core_clk(core_clk), .sys_rst(sysRst), .mdcPin(mdc), .mdioPinIn(mdioWire),
    .mdioPinOut(dutOut), .mdioPinOe(dutOe), .backplaneKrMode(krMode),
    .gigabitKxMode(kxMode), .patternLockFlag(stv[15]), .systemLaneAlignFlag(stv[14]),
    .lineSignalLost(stv[13]), .autozeroFinished(stv[12]), .gainLoopLocked(stv[11]),
    .lineSyncFlag(stv[10]), .decoderEnabled(stv[9]), .badCodewordFlag(stv[8]),
    .txUnderflow(stv[7]), .txOverflow(stv[6]), .rxUnderflow(stv[5]), .rxOverflow(stv[4]),
    .rxLinkOk(stv[3]), .txLinkOk(stv[2]), .systemSidePllLocked(stv[1]),
    .lineSidePllLocked(stv[0]), .patternBitError(patErr), .datapathReset(dpRst),
    .txBufferClear(txClr), .rxBufferClear(rxClr), .lineErrorTally(tally));
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  always @(posedge dpRst) dpCnt = dpCnt + 1;
  always @(posedge txClr) txCnt = txCnt + 1;
  always @(posedge rxClr) rxCnt = rxCnt + 1;
  task compare(input [15:0] got, input [15:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [4:0] dev, input [15:0] a, input [15:0] d);
    begin
      st.frame(2'b00, dev, a, rd);
      st.frame(2'b01, dev, d, rd);
    end
  endtask
  task rdReg(input [4:0] dev, input [15:0] a);
    begin
      st.frame(2'b00, dev, a, rd);
      st.frame(2'b11, dev, 16'h0000, rd);
    end
  endtask
  task setIn(input kr, input kx, input [15:0] s);
    begin
      @(posedge core_clk);
      #2;
      krMode = kr;
      kxMode = kx;
      stv = s;
    end
  endtask
  task t_reset_vals;
    begin
      rdReg(5'h1E, 16'h000E);
      compare(rd, 16'h0000);
      rdReg(5'h1E, 16'h000F);
      compare(rd, 16'h0000);
    end
  endtask
  // lane align bit reads inverted against the aligned input
  task t_status(input kr, input kx, input [15:0] s, input [15:0] exp);
    begin
      setIn(kr, kx, s);
      rdReg(5'h1E, 16'h000F);
      compare(rd, exp);
    end
  endtask
  task t_strobes;
    begin
      setIn(1'b0, 1'b0, 16'h0000);
      wr(5'h1E, 16'h000E, 16'h0008);
      compare(dpCnt[15:0], 16'h0001);
      rdReg(5'h1E, 16'h000E);
      compare(rd, 16'h0000);
      wr(5'h1E, 16'h000E, 16'h0006);
      compare({txCnt[7:0], rxCnt[7:0]}, 16'h0101);
      wr(5'h1E, 16'h000E, 16'h0000);
      compare({dpCnt[7:0], txCnt[3:0], rxCnt[3:0]}, 16'h0111);
      setIn(1'b1, 1'b0, 16'h0000);
      wr(5'h1E, 16'h000E, 16'h000E);
      compare({dpCnt[7:0], txCnt[3:0], rxCnt[3:0]}, 16'h0211);
      wr(5'h1E, 16'h000E, 16'hFFF1);
      rdReg(5'h1E, 16'h000E);
      compare(rd, 16'h00F1);
      wr(5'h01, 16'h000E, 16'h0008);
      compare(dpCnt[15:0], 16'h0002);
      rdReg(5'h01, 16'h000E);
      compare(rd, 16'hFFFF);
      rdReg(5'h1E, 16'h0020);
      compare(rd, 16'h0000);
    end
  endtask
  // datapath reset keeps register contents; read-increment steps the address
  task t_rdinc;
    begin
      setIn(1'b0, 1'b0, 16'h4003);
      wr(5'h1E, 16'h000E, 16'h00F9);
      compare(dpCnt[15:0], 16'h0003);
      st.frame(2'b00, 5'h1E, 16'h000E, rd);
      st.frame(2'b10, 5'h1E, 16'h0000, rd);
      compare(rd, 16'h00F1);
      st.frame(2'b11, 5'h1E, 16'h0000, rd);
      compare(rd, 16'h0003);
    end
  endtask
  task t_tally;
    begin
      setIn(1'b0, 1'b0, 16'h8000);
      for (i = 0; i < 5; i = i + 1) begin
        @(posedge core_clk);
        #2 patErr = 1'b1;
        @(posedge core_clk);
        #2 patErr = 1'b0;
      end
      rdReg(5'h1E, 16'h0010);
      compare(rd, 16'h0005);
      rdReg(5'h1E, 16'h0010);
      compare(rd, 16'h0000);
    end
  endtask
  task complete_run;
    begin
      $display("checks %0d errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  initial begin
    error_cnt = 0;
    checks_done = 0;
    dpCnt = 0;
    txCnt = 0;
    rxCnt = 0;
    sysRst = 1'b1;
    krMode = 1'b0;
    kxMode = 1'b0;
    patErr = 1'b0;
    stv = 16'h4000;
    repeat (8) @(posedge core_clk);
    #2 sysRst = 1'b0;
    t_reset_vals;
    t_status(1'b0, 1'b0, 16'hFFFF, 16'hBDFF);
    t_status(1'b0, 1'b1, 16'hFFFF, 16'hBD5F);
    t_status(1'b1, 1'b0, 16'hFFFF, 16'h3DFF);
    t_status(1'b0, 1'b0, 16'h2101, 16'h6001);
    t_strobes;
    t_rdinc;
    t_tally;
    complete_run;
  end
  initial begin
    #2000000;
    error_cnt = error_cnt + 1;
    complete_run;
  end
endmodule
bind crs_channel_regs crs_channel_regs_sva chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .backplaneKrMode(backplaneKrMode),
  .gigabitKxMode(gigabitKxMode), .patternBitError(patternBitError),
  .mdioPinOut(mdioPinOut), .mdioPinOe(mdioPinOe), .datapathReset(datapathReset),
  .txBufferClear(txBufferClear), .rxBufferClear(rxBufferClear),
  .lineErrorTally(lineErrorTally));
